//--- opaddr_pkg.sv
package opaddr_pkg;

  // Addressing modes selected by the decoder
  typedef enum logic [2:0] {
    mode_none,
    mode_absolute,
    mode_short_direct,
    mode_special_reg,
    mode_register,
    mode_reg_indirect,
    mode_based,
    mode_stack
  } addr_mode_e;

  // Stack access kinds
  typedef enum logic [1:0] {
    stack_push,
    stack_pop
  } stack_op_e;

  // Address map constants
  localparam logic [15:0] short_base_lo = 16'hfe00; // Page for bytes 80h-ffh
  localparam logic [15:0] short_base_hi = 16'hff00; // Page for bytes 00h-1fh
  localparam logic [15:0] sfr_base = 16'hff00;
  localparam logic [15:0] short_win_first = 16'hfe80;
  localparam logic [15:0] short_win_last = 16'hff1f;
  localparam logic [15:0] fast_ram_first = 16'hfe80;
  localparam logic [15:0] fast_ram_last = 16'hfeff;
  localparam logic [7:0] short_hi_limit = 8'h1f;
  localparam logic [7:0] short_lo_first = 8'h80;
  localparam int short_page_bit = 8;
  localparam int byte_reg_count = 8;
  localparam int pair_count = 4;

  // Operand request from the instruction decoder
  typedef struct packed {
    logic valid;
    addr_mode_e mode;
    logic [15:0] imm16;          // absolute_address_operand
    logic [7:0] imm8;            // Short, special-register or based offset
    logic [2:0] reg_field;       // Byte register code
    logic [1:0] pair_field;      // register_pair_operand code
    logic word_access;           // 16-bit operand
    stack_op_e stack_op;
  } operand_req_s;

  // Resolved operand address
  typedef struct packed {
    logic valid;
    logic is_memory;             // Address drives memory or special register
    logic [15:0] address;
    logic is_register;
    logic [2:0] byte_reg;        // Absolute byte register number 0..7
    logic [1:0] pair_reg;        // Absolute pair number 0..3
    logic word_access;
    logic short_range_err;       // Short byte 20h-7fh outside window
    logic odd_word_err;          // Odd word address in short window
    logic stack_outside_ram;     // Stack access left the fast RAM
  } operand_addr_s;

endpackage : opaddr_pkg

//--- operand_address_generator.sv
`timescale 1ns/1ps

// Function
// - An absolute operand uses the 16-bit immediate unchanged as the memory address.
// - Short direct addressing reaches the 160-byte window fe80h to ff1fh; bytes 20h-7fh give fe20h-fe7fh with short_range_err set.
// - For short direct bytes 80h-ffh address bit 8 is cleared, for 00h-1fh it is set.
// - A 16-bit short direct operand must sit at an even address and covers the pair from there.
// - Special-register addressing forms ff00h plus the immediate byte over ff00h to ffffh.
// - A byte register operand is chosen among eight by a 3-bit code field.
// - Byte registers X,A,C,B,E,D,L,H are numbers 0..7 and pairs AX,BC,DE,HL are 0..3.
// - Register indirect uses the full 16-bit register pair contents as the address.
// - Based addressing adds the zero-extended offset to the base pair and drops the carry.
// - Stack accesses use the stack pointer for pop and the stack pointer minus one for push.
module operand_address_generator
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Decoder request
  input opaddr_pkg::operand_req_s req,
  // Register file contents
  input wire logic [63:0] pair_contents,      // Four pairs, pair 0 in low bits
  input wire logic [15:0] base_register_pair,
  input wire logic [15:0] stack_pointer,
  // Resolved operand
  output opaddr_pkg::operand_addr_s result
);
  import opaddr_pkg::*;

  operand_addr_s result_d;
  // Registered answer, kept per concern so each field has one owner
  logic valid_q;
  logic is_memory_q;
  logic is_register_q;
  logic word_access_q;
  logic [15:0] address_q;
  logic [2:0] byte_reg_q;
  logic [1:0] pair_reg_q;
  logic short_range_err_q;
  logic odd_word_err_q;
  logic stack_outside_ram_q;
  logic [15:0] pair_value [pair_count];
  logic [15:0] short_addr;
  logic [15:0] based_sum;
  logic [15:0] stack_addr;
  logic short_in_hi;
  logic short_in_lo;

  // Split the packed register file into one word per pair
  genvar gi;
  generate
    for (gi = 0; gi < pair_count; gi++) begin : g_pair
      assign pair_value[gi] = pair_contents[gi*16 +: 16];
    end
  endgenerate

  // Short direct page: bit 8 picks between the RAM half and the register half
  assign short_in_hi = (req.imm8 <= short_hi_limit);
  assign short_in_lo = (req.imm8 >= short_lo_first);
  assign short_addr = short_in_hi ? (short_base_hi | {8'h00, req.imm8})
                                  : (short_base_lo | {8'h00, req.imm8});

  // Based sum keeps only 16 bits so the carry out of bit 15 is dropped
  assign based_sum = 16'(base_register_pair + {8'h00, req.imm8});

  // Pop reads at the pointer, push writes one below it
  assign stack_addr = (req.stack_op == stack_push) ? 16'(stack_pointer - 16'h0001)
                                                   : stack_pointer;

  // Resolve the operand combinationally, registered below
  always_comb begin
    result_d = '0;
    result_d.valid = req.valid;
    result_d.word_access = req.word_access;
    result_d.byte_reg = req.reg_field;
    result_d.pair_reg = req.pair_field;
    case (req.mode)
      mode_absolute: begin
        result_d.is_memory = 1'b1;
        result_d.address = req.imm16;
      end
      mode_short_direct: begin
        result_d.is_memory = 1'b1;
        result_d.address = short_addr;
        // Bytes 20h-7fh fall outside the window; flag rather than alias
        result_d.short_range_err = req.valid && !(short_in_hi || short_in_lo);
        result_d.odd_word_err = req.valid && req.word_access && req.imm8[0];
      end
      mode_special_reg: begin
        result_d.is_memory = 1'b1;
        result_d.address = sfr_base | {8'h00, req.imm8};
      end
      mode_register: begin
        // Codes are the absolute register numbers, so they pass through
        result_d.is_register = 1'b1;
      end
      mode_reg_indirect: begin
        result_d.is_memory = 1'b1;
        result_d.address = pair_value[req.pair_field];
      end
      mode_based: begin
        result_d.is_memory = 1'b1;
        result_d.address = based_sum;
      end
      mode_stack: begin
        result_d.is_memory = 1'b1;
        result_d.address = stack_addr;
        // Software owns the pointer; report misuse without blocking the access
        result_d.stack_outside_ram = req.valid &&
          ((stack_addr < fast_ram_first) || (stack_addr > fast_ram_last));
      end
      default: begin
        result_d.is_memory = 1'b0;
      end
    endcase
  end

  // Request qualifier and target kind; reset clears them so nothing looks valid
  always_ff @(posedge clock) begin
    if (reset) begin
      valid_q <= 1'b0;
      is_memory_q <= 1'b0;
      is_register_q <= 1'b0;
      word_access_q <= 1'b0;
    end else begin
      valid_q <= result_d.valid;
      is_memory_q <= result_d.is_memory;
      is_register_q <= result_d.is_register;
      word_access_q <= result_d.word_access;
    end
  end

  // Operand address; the answer appears one cycle after the request
  always_ff @(posedge clock) begin
    if (reset) begin
      address_q <= 16'h0000;
    end else begin
      address_q <= result_d.address;
    end
  end

  // Register select codes pass straight through
  always_ff @(posedge clock) begin
    if (reset) begin
      byte_reg_q <= 3'h0;
      pair_reg_q <= 2'h0;
    end else begin
      byte_reg_q <= result_d.byte_reg;
      pair_reg_q <= result_d.pair_reg;
    end
  end

  // Misuse flags only report; the access itself still goes ahead
  always_ff @(posedge clock) begin
    if (reset) begin
      short_range_err_q <= 1'b0;
      odd_word_err_q <= 1'b0;
      stack_outside_ram_q <= 1'b0;
    end else begin
      short_range_err_q <= result_d.short_range_err;
      odd_word_err_q <= result_d.odd_word_err;
      stack_outside_ram_q <= result_d.stack_outside_ram;
    end
  end

  // Output is a pure image of the flops, no logic in front of the port
  assign result = '{
    valid: valid_q,
    is_memory: is_memory_q,
    address: address_q,
    is_register: is_register_q,
    byte_reg: byte_reg_q,
    pair_reg: pair_reg_q,
    word_access: word_access_q,
    short_range_err: short_range_err_q,
    odd_word_err: odd_word_err_q,
    stack_outside_ram: stack_outside_ram_q
  };

  // Checks
  // Helper flops keep the register file as it stood at the previous edge
  logic [15:0] past_bhl;
  logic [15:0] past_sp;
  logic [63:0] past_pairs;
  always_ff @(posedge clock) begin
    past_bhl <= base_register_pair;
    past_sp <= stack_pointer;
    past_pairs <= pair_contents;
  end

  // A valid request of one addressing mode
  sequence s_req(addr_mode_e m);
    req.valid && req.mode == m;
  endsequence

  // A valid stack request in one direction
  sequence s_stack(stack_op_e s);
    req.valid && req.mode == mode_stack && req.stack_op == s;
  endsequence

  // A short direct request followed at once by a special-register request
  sequence s_short_then_sfr;
    s_req(mode_short_direct) ##1 s_req(mode_special_reg);
  endsequence

  // Absolute operands
  a_absolute_passes: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_absolute) |=> result.address == $past(req.imm16) && result.is_memory)
    else $error("absolute address altered");

  // Short direct window and its address layout
  a_short_window: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_short_direct) ##0 (req.imm8 <= short_hi_limit || req.imm8 >= short_lo_first)
    |=> result.address >= short_win_first && result.address <= short_win_last)
    else $error("short address outside window");

  a_short_bit_eight: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_short_direct) |=>
      result.address[short_page_bit] == ($past(req.imm8) <= short_hi_limit))
    else $error("short address bit 8 wrong");

  a_short_upper_bits: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_short_direct) |=>
      result.address[15:9] == 7'h7f && result.address[7:0] == $past(req.imm8))
    else $error("short address layout wrong");

  a_short_flag_range: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_short_direct) |=> result.short_range_err ==
      ($past(req.imm8) > short_hi_limit && $past(req.imm8) < short_lo_first))
    else $error("short range flag wrong");

  // Word operands in the short window
  a_short_odd_word: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_short_direct) ##0 (req.word_access && req.imm8[0]) |=> result.odd_word_err)
    else $error("odd word address not flagged");

  a_short_word_even: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_short_direct) ##0 (req.word_access && !req.imm8[0])
    |=> !result.odd_word_err && result.word_access)
    else $error("even word pair refused");

  // Special-register page
  a_sfr_page: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_special_reg) |=> result.address == {8'hff, $past(req.imm8)})
    else $error("special register address wrong");

  a_sfr_kind: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_special_reg) |=> result.is_memory && !result.is_register &&
      !result.short_range_err)
    else $error("special register access kind wrong");

  a_back_to_back: assert property (@(posedge clock) disable iff (reset)
    s_short_then_sfr |-> result.address[15:9] == 7'h7f
      ##1 result.address == {8'hff, $past(req.imm8)})
    else $error("back to back answers mixed up");

  // Register operands
  a_register_select: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_register) |=> result.is_register && !result.is_memory &&
      result.byte_reg == $past(req.reg_field) && result.pair_reg == $past(req.pair_field))
    else $error("register select wrong");

  a_register_no_address: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_register) |=> result.address == 16'h0000 && !result.short_range_err)
    else $error("register operand drove an address");

  // Register indirect and based operands
  a_indirect_pair: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_reg_indirect) |=>
      result.address == past_pairs[$past(req.pair_field)*16 +: 16])
    else $error("indirect address wrong");

  a_indirect_kind: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_reg_indirect) |=> result.is_memory && !result.is_register &&
      result.pair_reg == $past(req.pair_field))
    else $error("indirect access kind wrong");

  a_based_wrap: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_based) |=> result.address == 16'(past_bhl + {8'h00, $past(req.imm8)}))
    else $error("based address wrong");

  a_based_kind: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_based) |=> result.is_memory && !result.is_register)
    else $error("based access kind wrong");

  // Stack accesses
  a_stack_pointer: assert property (@(posedge clock) disable iff (reset)
    s_stack(stack_pop) |=> result.address == past_sp)
    else $error("stack pop address wrong");

  a_stack_push: assert property (@(posedge clock) disable iff (reset)
    s_stack(stack_push) |=> result.address == 16'(past_sp - 16'h0001))
    else $error("stack push address wrong");

  a_stack_ram_flag: assert property (@(posedge clock) disable iff (reset)
    s_req(mode_stack) |=> result.stack_outside_ram ==
      (result.address < fast_ram_first || result.address > fast_ram_last))
    else $error("stack range flag wrong");

  a_stack_flag_scope: assert property (@(posedge clock) disable iff (reset)
    req.mode != mode_stack |=> !result.stack_outside_ram)
    else $error("stack flag outside stack access");

  // Idle cycles raise neither valid nor any misuse flag
  a_idle_no_flags: assert property (@(posedge clock) disable iff (reset)
    !req.valid |=> !result.valid && !result.short_range_err && !result.odd_word_err &&
      !result.stack_outside_ram)
    else $error("flag raised without a request");

endmodule : operand_address_generator

//--- regfile_model.sv
`timescale 1ns/1ps

// Register pairs and stack pointer as the core presents them
module regfile_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Write port: select 0..3 a pair, 4 the stack pointer
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic stray,
  // Contents
  output logic [63:0] pair_contents,
  output logic [15:0] base_register_pair,
  output logic [15:0] stack_pointer
);
  // Writes land on the rising edge
  always_ff @(posedge clock) begin
    if (reset) begin
      pair_contents <= 64'h0;
      stack_pointer <= 16'hfeff;
    end else if (wr_en && wr_sel == 3'h4) begin
      // Kept in fast RAM unless a scenario wants a stray pointer
      stack_pointer <= stray ? wr_data : {9'h1fd, wr_data[6:0]};
    end else if (wr_en) begin
      pair_contents[wr_sel[1:0]*16 +: 16] <= wr_data;
    end
  end
  // The base pair is the last pair
  assign base_register_pair = pair_contents[63:48];
endmodule : regfile_model

//--- tb_operand_address_generator.sv
`timescale 1ns/1ps

module tb_operand_address_generator;
  import opaddr_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic wr_en = 1'b0;
  logic [2:0] wr_sel = 3'h0;
  logic [15:0] wr_data = 16'h0;
  logic stray = 1'b0;
  operand_req_s req = '0;
  operand_addr_s result;
  logic [63:0] pair_contents;
  logic [15:0] base_register_pair;
  logic [15:0] stack_pointer;
  int err_total = 0;
  int n_checks = 0;

  // 10 MHz clock
  always #50 clock = ~clock;

  regfile_model u_regs (.clock(clock), .reset(reset), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .stray(stray), .pair_contents(pair_contents),
    .base_register_pair(base_register_pair), .stack_pointer(stack_pointer));
  operand_address_generator u_dut (.clock(clock), .reset(reset), .req(req),
    .pair_contents(pair_contents), .base_register_pair(base_register_pair),
    .stack_pointer(stack_pointer), .result(result));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One register write, taken at the next rising edge
  task automatic set_reg(input logic [2:0] sel, input logic [15:0] d);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = d;
    @(negedge clock);
    wr_en = 1'b0;
  endtask : set_reg

  // Request at a falling edge; the answer is settled one cycle later
  task automatic issue(input addr_mode_e m, input logic [15:0] v, input logic [2:0] r = 3'h0,
      input logic w = 1'b0, input stack_op_e s = stack_push);
    req.valid = 1'b1;
    req.mode = m;
    req.imm16 = v;
    req.imm8 = v[7:0];
    req.reg_field = r;
    req.pair_field = r[1:0];
    req.word_access = w;
    req.stack_op = s;
    @(negedge clock);
  endtask : issue

  task automatic direct_forms;
    logic [7:0] b [5] = '{8'h80, 8'hff, 8'h00, 8'h1f, 8'h20};
    issue(mode_absolute, 16'hfe80);
    check("absolute", result.address, 16'hfe80);
    check("abs kind", {14'h0, result.valid, result.is_memory}, 16'h0003);
    issue(mode_absolute, 16'h0001);
    check("absolute", result.address, 16'h0001);
    foreach (b[i]) begin
      issue(mode_short_direct, {8'h0, b[i]});
      check("short", result.address, {7'h7f, b[i] <= 8'h1f, b[i]});
      check("short range", 16'(result.short_range_err), 16'(i == 4));
      issue(mode_special_reg, {8'h0, b[i]});
      check("special", result.address, {8'hff, b[i]});
    end
    issue(mode_short_direct, 16'h0081, 3'h0, 1'b1);
    check("odd word", 16'(result.odd_word_err), 16'h1);
    check("word flag", 16'(result.word_access), 16'h0001);
    issue(mode_short_direct, 16'h0080, 3'h0, 1'b1);
    check("even word", 16'(result.odd_word_err), 16'h0);
  endtask : direct_forms

  task automatic register_forms;
    for (int k = 0; k < 8; k++) begin
      issue(mode_register, 16'h0, 3'(k));
      check("byte reg", 16'(result.byte_reg), 16'(k));
      check("pair reg", 16'(result.pair_reg), 16'(k % 4));
      check("reg kind", {14'h0, result.is_register, result.is_memory}, 16'h0002);
    end
    issue(mode_none, 16'h1234);
    check("no operand", {14'h0, result.is_register, result.is_memory}, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      set_reg(3'(k), 16'ha5f0 | 16'(k));
      issue(mode_reg_indirect, 16'h0, 3'(k));
      check("indirect", result.address, 16'ha5f0 | 16'(k));
    end
    set_reg(3'h3, 16'hfff8);
    issue(mode_based, 16'h0010);
    check("based wrap", result.address, 16'h0008);
    set_reg(3'h3, 16'h0000);
    issue(mode_based, 16'h00ff);
    check("based zero ext", result.address, 16'h00ff);
  endtask : register_forms

  task automatic stack_forms;
    set_reg(3'h4, 16'hfe90);
    issue(mode_stack, 16'h0, 3'h0, 1'b0, stack_push);
    check("push", result.address, 16'hfe8f);
    issue(mode_stack, 16'h0, 3'h0, 1'b0, stack_pop);
    check("pop", result.address, 16'hfe90);
    check("in ram", 16'(result.stack_outside_ram), 16'h0);
    stray = 1'b1;
    set_reg(3'h4, 16'h0100);
    issue(mode_stack, 16'h0, 3'h0, 1'b0, stack_pop);
    check("stray", 16'(result.stack_outside_ram), 16'h1);
  endtask : stack_forms

  task automatic wrap_up;
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    direct_forms();
    register_forms();
    stack_forms();
    wrap_up();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule : tb_operand_address_generator
